//--- pkg/tsm_pkg.sv
// Shared constants, types and helpers for both ends of the shared-pin memory port.
// Functional notes
// R01: Device releases data lines when drive permit low.
// R02: Data bus 8 to 1024 bits, power of two.
// R03: Fabric drives one lane select per byte.
// R04: Side-effect-free device may ignore lanes on reads.
// R05: Multiple lanes contiguous, power-of-two, size aligned.
// R06: 32-bit legal lanes: all, halves, single bytes.
// R07: Lane write strobe equals write AND lane select.
// R08: First-cycle flag marks only each transfer's first cycle.
// R09: Signals active high; low variants mean the same.
// R10: Device address LSB taken from byte address bit.
// R11: Drive permit asserted only during read transfers.
// R12: Active-low write request low only during writes.
// R13: Write data held for configured hold cycles.
// R14: Pipelined reads return after fixed latency exactly.
// R15: Outstanding pipelined reads drain before any write.
// R16: Device ignores inputs unless device select asserted.
// R17: Select, address, data stable setup cycles before strobe.
// R18: After reset fabric idle and not driving data.
package tsm_pkg;
    localparam int          DATA_W     = 32;
    localparam int          ADDR_W     = 20;
    localparam int          READ_LAT   = 2;
    localparam int          MEM_WORDS  = 1024;
    localparam int          TIM_W      = 4;
    // Register byte offsets of the controller.
    localparam logic [7:0]  OFS_ADDR   = 8'h00;
    localparam logic [7:0]  OFS_WDATA  = 8'h04;
    localparam logic [7:0]  OFS_CMD    = 8'h08;
    localparam logic [7:0]  OFS_TIMING = 8'h0C;
    localparam logic [7:0]  OFS_STATUS = 8'h10;
    localparam logic [7:0]  OFS_RDATA  = 8'h14;
    // Field positions.
    localparam int          CMD_WR_BIT    = 8;
    localparam int          TIM_SETUP_LSB = 0;
    localparam int          TIM_WAIT_LSB  = 4;
    localparam int          TIM_HOLD_LSB  = 8;
    localparam int          STS_BUSY      = 0;
    localparam int          STS_RVALID    = 1;
    localparam int          STS_GO        = 2;
    localparam int          STS_PEND_LSB  = 4;
    // Reset values.
    localparam logic [31:0] TIMING_RST = 32'h0000_0000;
    localparam logic [31:0] ADDR_RST   = 32'h0000_0000;
    localparam logic [31:0] CMD_RST    = 32'h0000_000F;
    // Bus encodings.
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;

    typedef enum logic [1:0] {
        XS_IDLE   = 2'h0,
        XS_SETUP  = 2'h1,
        XS_ACCESS = 2'h3,
        XS_HOLD   = 2'h2
    } xfer_state_t;

    // Byte-address bit that feeds the device's lowest address line.
    function automatic int addr_lsb(input int dw);
        return $clog2(dw / 8);
    endfunction
endpackage

//--- pkg/tsm_port_if.sv
// Shared-pin memory port joining the fabric end and the device end.
`timescale 1ns/1ps
`default_nettype none
interface tsm_port_if #(
    parameter int DW = tsm_pkg::DATA_W,
    parameter int AW = tsm_pkg::ADDR_W
);
    logic [AW-1:0]   addr;
    logic            chip_sel;
    logic            rd;
    logic            direction_pin;
    logic            out_permit;
    logic [DW/8-1:0] lane_sel;
    logic [DW/8-1:0] per_lane_write_pin_n;
    logic            first_cycle;
    logic [DW-1:0]   fab_dq_o;
    logic            fab_dq_oe_n;
    logic [DW-1:0]   dev_dq_o;
    logic            dev_dq_oe_n;
    logic [DW-1:0]   dq;

    // Level of the shared data lines, worked out from the two enables.
    assign dq = !fab_dq_oe_n ? fab_dq_o : (!dev_dq_oe_n ? dev_dq_o : '0);

    modport fabric (
        output addr, chip_sel, rd, direction_pin, out_permit, lane_sel,
        output per_lane_write_pin_n, first_cycle, fab_dq_o, fab_dq_oe_n,
        input  dq
    );
    modport device (
        input  addr, chip_sel, rd, direction_pin, out_permit, lane_sel,
        input  per_lane_write_pin_n, first_cycle, dq,
        output dev_dq_o, dev_dq_oe_n
    );
endinterface
`default_nettype wire

//--- verilog/phase_timer.sv
// Down counter that times setup, write wait and hold phases.
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
    parameter int W = tsm_pkg::TIM_W
) (
    input  wire logic         CLOCK,
    input  wire logic         RST,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    // A zero-width counter cannot time any phase.
    if (W < 1) begin : g_bad_w
        $error("bad W");
    end

    logic [W-1:0] cnt_q;

    // Loads a count and steps down to zero.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign done = (cnt_q == '0);
endmodule // phase_timer
`default_nettype wire

//--- verilog/tsm_device_end.sv
// Fixed-latency synchronous memory on the shared-pin port.
`timescale 1ns/1ps
`default_nettype none
module tsm_device_end #(
    parameter int DW    = tsm_pkg::DATA_W,
    parameter int AW    = tsm_pkg::ADDR_W,
    parameter int LAT   = tsm_pkg::READ_LAT,
    parameter int WORDS = tsm_pkg::MEM_WORDS
) (
    input  wire logic  CLOCK,
    input  wire logic  RST,
    tsm_port_if.device PORT,
    output logic [15:0] ACCESS_COUNT
);
    localparam int LSB = tsm_pkg::addr_lsb(DW);
    localparam int IW  = $clog2(WORDS);
    localparam int NL  = DW / 8;

    // Refuses widths and depths that the word mapping cannot serve.
    if (DW < 8 || DW > 1024 || (DW & (DW - 1)) != 0) begin : g_bad_dw
        $error("bad DW");
    end
    if (LAT < 1 || IW + LSB > AW) begin : g_bad_lat
        $error("bad LAT or WORDS");
    end

    logic [DW-1:0] mem [WORDS];
    logic [DW-1:0] pipe_q [LAT];
    logic [LAT-1:0] vld_q;
    logic [15:0]    count_q;

    // Word index from the byte address.
    wire [IW-1:0] widx    = PORT.addr[LSB +: IW]; // see R10
    wire          sel     = PORT.chip_sel; // see R16
    wire          do_wr   = sel && !PORT.direction_pin && (PORT.per_lane_write_pin_n != '1);
    wire          do_rd   = sel && PORT.rd && PORT.direction_pin;
    wire          ret_now = vld_q[LAT-1];

    // Lane strobes, gated by chip select and the write request, decide which bytes are stored.
    always_ff @(posedge CLOCK) begin
        for (int i = 0; i < NL; i++) begin
            if (do_wr && !PORT.per_lane_write_pin_n[i]) begin // see R07
                mem[widx][8*i +: 8] <= PORT.dq[8*i +: 8];
            end
        end
    end

    // Read pipeline: the whole word is fetched and lane selects ignored.
    always_ff @(posedge CLOCK) begin
        pipe_q[0] <= mem[widx]; // see R04
        for (int k = 1; k < LAT; k++) begin
            pipe_q[k] <= pipe_q[k-1];
        end
    end

    // Valid bits track each accepted read to its return cycle.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            vld_q   <= '0;
            count_q <= 16'h0000;
        end else begin
            vld_q   <= LAT'({vld_q, do_rd}); // see R14
            count_q <= count_q + 16'((do_wr || do_rd) ? 1 : 0);
        end
    end

    // Output data rides straight off the last pipeline stage.
    assign PORT.dev_dq_o    = pipe_q[LAT-1];
    assign PORT.dev_dq_oe_n = !(ret_now && PORT.out_permit); // see R01
    assign ACCESS_COUNT     = count_q;
endmodule // tsm_device_end
`default_nettype wire

//--- verilog/tsm_fabric_end.sv
// Fabric end: AHB-Lite controlled sequencer that runs transfers on the shared pins.
`timescale 1ns/1ps
`default_nettype none
module tsm_fabric_end #(
    parameter int DW  = tsm_pkg::DATA_W,
    parameter int AW  = tsm_pkg::ADDR_W,
    parameter int LAT = tsm_pkg::READ_LAT
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic [1:0]       HRESP,
    tsm_port_if.fabric       PORT
);
    localparam int NL = DW / 8;
    localparam int TW = tsm_pkg::TIM_W;

    // Refuses parameters that the register map cannot serve.
    if (DW != 32) begin : g_bad_dw
        $error("register map serves a 32-bit port only");
    end
    if (LAT < 1 || LAT > 8 || AW > 32) begin : g_bad_lat
        $error("bad LAT or AW");
    end

    // ******************************************************************
    // Register file on AHB-Lite
    // ******************************************************************
    logic [31:0]   addr_q, wdata_q, cmd_q, timing_q, rdata_q, hrdata_q;
    logic          go_q, rvalid_q, ap_wr_q;
    logic [7:0]    ap_ofs_q;
    logic          ap_valid_q;

    wire       ap_take = HSEL && HREADY && HTRANS == tsm_pkg::HTRANS_NONSEQ;
    wire [7:0] ofs     = HADDR[7:0];
    wire       dp_wr   = ap_valid_q && ap_wr_q;
    wire       wr_cmd  = dp_wr && ap_ofs_q == tsm_pkg::OFS_CMD;
    wire       rd_rdat = ap_take && !HWRITE && ofs == tsm_pkg::OFS_RDATA;

    tsm_pkg::xfer_state_t state_q, state_d;
    logic [LAT-1:0] ret_q;
    logic           captured;

    // Status word shows the sequencer's own state.
    wire [31:0] status = {24'h0, 4'(ret_q), 1'b0, go_q, rvalid_q, state_q != tsm_pkg::XS_IDLE};

    // Read selection for the address phase.
    wire [31:0] rd_mux =
        (ofs == tsm_pkg::OFS_ADDR)   ? addr_q   :
        (ofs == tsm_pkg::OFS_WDATA)  ? wdata_q  :
        (ofs == tsm_pkg::OFS_CMD)    ? cmd_q    :
        (ofs == tsm_pkg::OFS_TIMING) ? timing_q :
        (ofs == tsm_pkg::OFS_STATUS) ? status   :
        (ofs == tsm_pkg::OFS_RDATA)  ? rdata_q  : 32'h0000_0000;

    wire start;

    // Address phase capture and registered read data.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ap_valid_q <= 1'b0;
            ap_wr_q    <= 1'b0;
            ap_ofs_q   <= 8'h00;
            hrdata_q   <= 32'h0000_0000;
        end else begin
            ap_valid_q <= ap_take;
            ap_wr_q    <= HWRITE;
            ap_ofs_q   <= ofs;
            hrdata_q   <= (ap_take && !HWRITE) ? rd_mux : hrdata_q;
        end
    end

    // Data phase writes; a command write while one waits is dropped.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            addr_q   <= tsm_pkg::ADDR_RST;
            wdata_q  <= 32'h0000_0000;
            cmd_q    <= tsm_pkg::CMD_RST;
            timing_q <= tsm_pkg::TIMING_RST;
        end else if (dp_wr) begin
            if (ap_ofs_q == tsm_pkg::OFS_ADDR) begin
                addr_q <= HWDATA;
            end else if (ap_ofs_q == tsm_pkg::OFS_WDATA) begin
                wdata_q <= HWDATA;
            end else if (ap_ofs_q == tsm_pkg::OFS_CMD && !go_q) begin
                cmd_q <= HWDATA;
            end else if (ap_ofs_q == tsm_pkg::OFS_TIMING) begin
                timing_q <= HWDATA;
            end
        end
    end

    // Go and read-valid flags; for read-valid, setting wins over clearing.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            go_q     <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            go_q     <= (wr_cmd && !go_q) || (go_q && !start);
            rvalid_q <= captured || (rvalid_q && !rd_rdat);
            rdata_q  <= captured ? PORT.dq : rdata_q;
        end
    end

    // ******************************************************************
    // Transfer sequencer
    // ******************************************************************
    logic [AW-1:0] xa_q;
    logic [NL-1:0] xbe_q;
    logic          xwr_q;
    logic [DW-1:0] xd_q;

    wire [TW-1:0] t_setup = timing_q[tsm_pkg::TIM_SETUP_LSB +: TW];
    wire [TW-1:0] t_wait  = timing_q[tsm_pkg::TIM_WAIT_LSB +: TW];
    wire [TW-1:0] t_hold  = timing_q[tsm_pkg::TIM_HOLD_LSB +: TW];
    wire          c_wr    = cmd_q[tsm_pkg::CMD_WR_BIT];
    wire          is_wr   = (state_q == tsm_pkg::XS_IDLE) ? c_wr : xwr_q;
    assign start = go_q && state_q == tsm_pkg::XS_IDLE && !(c_wr && ret_q != '0); // see R15
    assign captured = ret_q[LAT-1];

    logic          t_load;
    logic [TW-1:0] t_val;
    wire           t_done;

    phase_timer #(.W(TW)) u_timer (
        .CLOCK (CLOCK),
        .RST   (RST),
        .load  (t_load),
        .value (t_val),
        .done  (t_done)
    );

    // Next state and timer loads; reads strobe a single cycle.
    always_comb begin
        state_d = state_q;
        t_load  = 1'b0;
        t_val   = '0;
        case (state_q)
            tsm_pkg::XS_IDLE: begin
                if (start && t_setup != '0) begin
                    state_d = tsm_pkg::XS_SETUP; // see R17
                    t_load  = 1'b1;
                    t_val   = t_setup - TW'(1);
                end else if (start) begin
                    state_d = tsm_pkg::XS_ACCESS;
                    t_load  = 1'b1;
                    t_val   = c_wr ? t_wait : '0;
                end
            end
            tsm_pkg::XS_SETUP: begin
                if (t_done) begin
                    state_d = tsm_pkg::XS_ACCESS;
                    t_load  = 1'b1;
                    t_val   = xwr_q ? t_wait : '0;
                end
            end
            tsm_pkg::XS_ACCESS: begin
                if (t_done && xwr_q && t_hold != '0) begin
                    state_d = tsm_pkg::XS_HOLD; // see R13
                    t_load  = 1'b1;
                    t_val   = t_hold - TW'(1);
                end else if (t_done) begin
                    state_d = tsm_pkg::XS_IDLE;
                end
            end
            tsm_pkg::XS_HOLD: begin
                if (t_done) begin
                    state_d = tsm_pkg::XS_IDLE;
                end
            end
            default: state_d = tsm_pkg::XS_IDLE;
        endcase
    end

    // Values the pins take after this edge.
    wire           busy_d = state_d != tsm_pkg::XS_IDLE;
    wire           acc_d  = state_d == tsm_pkg::XS_ACCESS;
    wire           rd_d   = acc_d && !is_wr;
    wire [LAT-1:0] ret_d  = LAT'({ret_q, PORT.rd}); // see R14

    logic          cs_q, rdp_q, dirp_q, perm_q, first_q, doe_n_q;
    logic [NL-1:0] lane_q, lwn_q;

    // Latch the order at start and register every pin.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q <= tsm_pkg::XS_IDLE;
            ret_q   <= '0;
            xa_q    <= '0;
            xbe_q   <= '0;
            xwr_q   <= 1'b0;
            xd_q    <= '0;
            cs_q    <= 1'b0; // see R18
            rdp_q   <= 1'b0;
            dirp_q  <= 1'b1;
            perm_q  <= 1'b0;
            first_q <= 1'b0;
            doe_n_q <= 1'b1;
            lane_q  <= '0;
            lwn_q   <= '1;
        end else begin
            state_q <= state_d;
            ret_q   <= ret_d;
            if (start) begin
                xa_q  <= addr_q[AW-1:0];
                xbe_q <= cmd_q[NL-1:0]; // see R03, R05, R06
                xwr_q <= c_wr;
                xd_q  <= wdata_q;
            end
            cs_q    <= busy_d;
            rdp_q   <= rd_d;
            dirp_q  <= !(acc_d && is_wr); // see R12
            perm_q  <= (busy_d && !is_wr) || ret_d != '0; // see R11
            first_q <= start; // see R08
            doe_n_q <= !(busy_d && is_wr);
            lane_q  <= start ? cmd_q[NL-1:0] : xbe_q;
            lwn_q   <= ~((acc_d && is_wr) ? (start ? cmd_q[NL-1:0] : xbe_q) : '0); // see R07
        end
    end

    assign PORT.addr                 = xa_q;
    assign PORT.chip_sel             = cs_q;
    assign PORT.rd                   = rdp_q;
    assign PORT.direction_pin        = dirp_q;
    assign PORT.out_permit           = perm_q;
    assign PORT.first_cycle          = first_q;
    assign PORT.lane_sel             = lane_q;
    assign PORT.per_lane_write_pin_n = lwn_q; // see R09
    assign PORT.fab_dq_o             = xd_q; // see R02
    assign PORT.fab_dq_oe_n          = doe_n_q;
    assign HRDATA                    = hrdata_q;
    assign HREADYOUT                 = 1'b1;
    assign HRESP                     = tsm_pkg::HRESP_OKAY;
endmodule // tsm_fabric_end
`default_nettype wire

//--- dv/tsm_port_chk.sv
// Concurrent checks on the shared-pin port between the fabric end and the device end.
`timescale 1ns/1ps
`default_nettype none
module tsm_port_chk #(
    parameter int LAT = tsm_pkg::READ_LAT
) (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic [19:0] addr,
    input wire logic        chip_sel,
    input wire logic        rd,
    input wire logic        direction_pin,
    input wire logic        out_permit,
    input wire logic [3:0]  lane_sel,
    input wire logic [3:0]  per_lane_write_pin_n,
    input wire logic        first_cycle,
    input wire logic [31:0] fab_dq_o,
    input wire logic        fab_dq_oe_n,
    input wire logic        dev_dq_oe_n
);
    // ****************************************
    // Read return tracking and properties
    // ****************************************
    logic [LAT:0] sh_q;
    logic [LAT:0] sh_d;
    logic         pend;

    // Bit LAT-1 of the pipe marks the cycle in which read data must be on the lines.
    assign sh_d = {sh_q[LAT-1:0], rd};
    assign pend = |sh_q[LAT-1:0];

    // Shifts one bit per cycle, taking in the read strobe.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    property p_dev_release; !out_permit |-> dev_dq_oe_n; endproperty
    a_dev_release: assert property (p_dev_release) else $error("device drives without permit");
    property p_latency; (!dev_dq_oe_n) == sh_q[LAT-1]; endproperty
    a_latency: assert property (p_latency) else $error("read return off its fixed latency");
    property p_permit; out_permit |-> direction_pin && fab_dq_oe_n; endproperty
    a_permit: assert property (p_permit) else $error("permit outside a read");
    property p_permit_hold; (rd || pend) |-> out_permit && direction_pin; endproperty
    a_permit_hold: assert property (p_permit_hold) else $error("permit dropped early");
    property p_strobe; per_lane_write_pin_n == (direction_pin ? 4'hF : ~lane_sel); endproperty
    a_strobe: assert property (p_strobe) else $error("lane strobes wrong");
    property p_dir; !direction_pin |-> chip_sel && !fab_dq_oe_n && !pend && !rd; endproperty
    a_dir: assert property (p_dir) else $error("write request outside a write");
    property p_first; first_cycle == (chip_sel && !$past(chip_sel)); endproperty
    a_first: assert property (p_first) else $error("first cycle flag wrong");
    property p_stable;
        chip_sel && $past(chip_sel) |->
            $stable(addr) && $stable(lane_sel) && (fab_dq_oe_n || $stable(fab_dq_o));
    endproperty
    a_stable: assert property (p_stable) else $error("address or data moved");
    property p_drive; !fab_dq_oe_n |-> chip_sel && !out_permit; endproperty
    a_drive: assert property (p_drive) else $error("fabric drives while idle");
endmodule // tsm_port_chk
`default_nettype wire

//--- dv/tb_shared_pin_tristate_memory_port.sv
// Self-checking bench joining the fabric end and the device end.
`timescale 1ns/1ps
`default_nettype none
module tb_shared_pin_tristate_memory_port;
    // ****************************************
    // Signals, instances and tasks
    // ****************************************
    logic        clock;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [1:0]  hresp;
    logic [15:0] access_count;
    logic [15:0] lfsr_q;
    logic [31:0] mem_m [int];
    logic [31:0] r;
    logic [31:0] old;
    logic [31:0] tim;
    logic [2:0]  hsize;
    int          n_acc;
    logic [3:0]  pats [7] = '{4'hF, 4'h3, 4'hC, 4'h1, 4'h2, 4'h4, 4'h8};
    int          n_errors;
    int          n_tests;

    tsm_port_if port_if ();
    tsm_fabric_end tsm_fabric_end_inst (.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PORT(port_if));
    tsm_device_end tsm_device_end_inst (.CLOCK(clock), .RST(rst), .PORT(port_if),
        .ACCESS_COUNT(access_count));
    tsm_port_chk tsm_port_chk_inst (.CLOCK(clock), .RST(rst), .addr(port_if.addr),
        .chip_sel(port_if.chip_sel), .rd(port_if.rd), .direction_pin(port_if.direction_pin),
        .out_permit(port_if.out_permit), .lane_sel(port_if.lane_sel),
        .per_lane_write_pin_n(port_if.per_lane_write_pin_n), .first_cycle(port_if.first_cycle),
        .fab_dq_o(port_if.fab_dq_o), .fab_dq_oe_n(port_if.fab_dq_oe_n),
        .dev_dq_oe_n(port_if.dev_dq_oe_n));

    // Steps the bench's pseudo-random source and returns a word from it.
    function automatic logic [31:0] rnd();
        logic [31:0] v;
        for (int i = 0; i < 2; i++) begin
            lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            v = {v[15:0], lfsr_q};
        end
        return v;
    endfunction

    // Byte offset of the lowest selected lane, so that the address agrees with the lanes.
    function automatic int lane_ofs(input logic [3:0] ln);
        return ln[0] ? 0 : ln[1] ? 1 : ln[2] ? 2 : 3;
    endfunction

    // Compares a seen value with the expected one and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One single word transfer on the register bus, entered just after a rising edge.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        hsel   <= 1'b1;
        htrans <= tsm_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    // Polls the status word until the masked bits reach the wanted value.
    task automatic wait_sts(input logic [31:0] m, input logic [31:0] v);
        logic [31:0] s;
        for (int k = 0; k < 64; k++) begin
            ahb(1'b0, tsm_pkg::OFS_STATUS, 32'h0, s);
            if ((s & m) === v) break;
        end
        chk(s & m, v);
    endtask

    // Starts one port transfer at byte address a and updates the model on writes.
    task automatic xfer(input logic w, input logic [3:0] ln, input logic [19:0] a,
                        input logic [31:0] d, input logic wt);
        ahb(1'b1, tsm_pkg::OFS_ADDR, {12'h000, a}, r);
        ahb(1'b1, tsm_pkg::OFS_WDATA, d, r);
        ahb(1'b1, tsm_pkg::OFS_CMD, {23'h0, w, 4'h0, ln}, r);
        n_acc += w ? int'(tim[tsm_pkg::TIM_WAIT_LSB +: 4]) + 1 : 1;
        for (int b = 0; b < 4; b++) begin
            if (w && ln[b]) mem_m[int'(a[19:2])][8*b+:8] = d[8*b+:8];
        end
        if (wt && w) wait_sts(32'h5, 32'h0);
        if (wt && !w) begin
            wait_sts(32'h2, 32'h2);
            ahb(1'b0, tsm_pkg::OFS_RDATA, 32'h0, r);
            chk(r, mem_m[int'(a[19:2])]);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        tally_and_finish();
    end

    // Main sequence: reset state, lane patterns, then read followed by write.
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata, tim, n_errors, n_tests, n_acc} = '0;
        lfsr_q = 16'hEDCE;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({27'h0, port_if.chip_sel, port_if.rd, port_if.out_permit, port_if.fab_dq_oe_n,
             port_if.direction_pin}, 32'h3);
        ahb(1'b1, 8'h18, 32'hFFFFFFFF, r);
        for (int i = 0; i < 6; i++) begin
            ahb(1'b0, 8'(4 * i + 8), 32'h0, r);
            chk(r, (i == 0) ? tsm_pkg::CMD_RST : 32'h0);
        end
        $display("reset test done");
        for (int i = 0; i < 16; i++) xfer(1'b1, 4'hF, 20'(4 * i), rnd(), 1'b1);
        for (int i = 0; i < 7; i++) begin
            tim = rnd() & 32'h333;
            ahb(1'b1, tsm_pkg::OFS_TIMING, tim, r);
            xfer(1'b1, pats[i], 20'(4 * i + lane_ofs(pats[i])), rnd(), 1'b1);
            xfer(1'b0, pats[i], 20'(4 * i + lane_ofs(pats[i])), 32'h0, 1'b1);
        end
        $display("lane pattern test done");
        // The write order lands while the read is still returning, so it must wait.
        tim = 32'h0;
        ahb(1'b1, tsm_pkg::OFS_TIMING, tim, r);
        old = mem_m[9];
        mem_m[9] = rnd();
        ahb(1'b1, tsm_pkg::OFS_ADDR, 32'h0000_0024, r);
        ahb(1'b1, tsm_pkg::OFS_WDATA, mem_m[9], r);
        ahb(1'b1, tsm_pkg::OFS_CMD, 32'h0000_000F, r);
        ahb(1'b1, tsm_pkg::OFS_CMD, 32'h0000_010F, r);
        n_acc += 2;
        wait_sts(32'h4, 32'h0);
        wait_sts(32'h2, 32'h2);
        ahb(1'b0, tsm_pkg::OFS_RDATA, 32'h0, r);
        chk(r, old);
        wait_sts(32'h5, 32'h0);
        xfer(1'b0, 4'hF, 20'h00024, 32'h0, 1'b1);
        chk({16'h0000, access_count}, 32'(n_acc));
        $display("read then write test done");
        tally_and_finish();
    end
endmodule // tb_shared_pin_tristate_memory_port
`default_nettype wire
